// file: rtl/dcc_regs_map.svh
// register map of the datapath and digital clock configuration bank
// assumes an 8-bit register port with 12-bit byte addresses
`ifndef DCC_REGS_MAP_SVH
`define DCC_REGS_MAP_SVH

// register addresses
`define DCC_ADDR_CLK_POL 12'h009d
`define DCC_ADDR_LOOP_TEST 12'h00a0
`define DCC_ADDR_LANES_INTERP 12'h0110
`define DCC_ADDR_DATAPATH 12'h0111

// polarity register fields
`define DCC_BIT_CLK_INV 2
`define DCC_BIT_DUTY_EN 1
`define DCC_BIT_CROSS_EN 0
`define DCC_RST_CLK_POL 3'h3
`define DCC_RST_CLK_INV 1'b0
`define DCC_RST_DUTY_EN 1'b1
`define DCC_RST_CROSS_EN 1'b1

// loop clock test register fields
`define DCC_BIT_TEST_EN 7
`define DCC_RST_TEST_DIV 2'h0
`define DCC_RST_TEST_EN 1'b0
`define DCC_TEST_DIV_MSB 1
`define DCC_TEST_DIV_LSB 0

// lanes and interpolation fields
`define DCC_RST_LANES 4'h8
`define DCC_RST_INTERP 4'h1
`define DCC_LANES_MSB 7
`define DCC_LANES_LSB 4
`define DCC_INTERP_MSB 3
`define DCC_INTERP_LSB 0
`define DCC_INTERP_6X 4'h4
`define DCC_INTERP_8X 4'h5
`define DCC_INTERP_12X 4'h6
`define DCC_INTERP_16X 4'h7
`define DCC_INTERP_24X 4'h8

// datapath register fields
`define DCC_BIT_SINC_EN 7
`define DCC_BIT_MODULATION_OSCILLATOR_ENABLE 6
`define DCC_BIT_FILTER_BANDWIDTH_SELECT 4
`define DCC_BIT_DDS_EN 2
`define DCC_BIT_SIDEBAND 1
`define DCC_BIT_HB_EN 0
`define DCC_MASK_DATAPATH 8'hd7
`define DCC_RST_DATAPATH 8'h00
`define DCC_RST_EN_OFF 1'b0

`endif

// file: rtl/dcc_pkg.sv
// types shared by the configuration bank
// assumes the map header supplies the numeric constants
package dcc_pkg;
  // decoded interpolation ratio; gray along the 6x..24x ladder
  typedef enum logic [2:0] {
    DCC_INTERP_NONE = 3'b000,
    DCC_INTERP_X6 = 3'b001,
    DCC_INTERP_X8 = 3'b011,
    DCC_INTERP_X12 = 3'b010,
    DCC_INTERP_X16 = 3'b110,
    DCC_INTERP_X24 = 3'b111
  } dcc_interp_e;
endpackage : dcc_pkg

// file: rtl/dcc_test_div.sv
// divider for the loop clock test output
// assumes the loop clock is sampled on sys_clk; ratio 2^(div+1)
`timescale 1ns/1ps
module dcc_test_div #(
  parameter int CNT_W = 4
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // control
  input wire logic enable_i,
  input wire logic [1:0] div_sel_i,
  // loop clock edges seen in the system domain
  input wire logic loop_edge_i,
  // divided test clock
  output logic test_clk_o
);
  logic [CNT_W-1:0] cnt_r; // loop edge counter
  logic [CNT_W-1:0] half_w; // toggle point

  // half period in loop edges: 1,2,4,8
  assign half_w = CNT_W'(1) << div_sel_i;

  // count loop edges, toggle at half period; held low while off
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r <= '0;
      test_clk_o <= 1'b0;
    end else if (!enable_i) begin
      cnt_r <= '0; // see R4
      test_clk_o <= 1'b0; // see R4
    end else if (loop_edge_i) begin
      if (cnt_r + CNT_W'(1) >= half_w) begin
        cnt_r <= '0;
        test_clk_o <= ~test_clk_o; // see R5
      end else begin
        cnt_r <= cnt_r + CNT_W'(1);
      end
    end
  end
endmodule : dcc_test_div

// file: rtl/dcc_regs.sv
// How it works
// R1 - invert bit flips loop digital clock polarity
// R2 - duty correction enabled while bit set
// R3 - cross control enabled while bit set
// R4 - test output driven only when enabled
// R5 - two-bit field selects test clock divide
// R6 - lane count from bits seven to four
// R7 - software changes lanes/interp only in reset
// R8 - interpolation codes decode to 6x..24x
// R9 - sinc filter inserted when bit seven set
// R10 - bandwidth bit selects 80 or 90 percent
// R11 - sideband bit selects upper or lower
// R12 - nco, dds, halfband enables reset off
// R13 - reserved bits read zero, ignore writes
//
// configuration register bank for datapath and digital clock
// assumes a simple synchronous register port on sys_clk
`timescale 1ns/1ps
`include "dcc_regs_map.svh"
module dcc_regs #(
  parameter int ADDR_W = 12
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_rvalid_o,
  // loop clock from the delay-locked loop, asynchronous
  input wire logic loop_clk_i,
  // digital clock controls
  output logic digital_clock_invert_o,
  output logic digital_clock_o,
  output logic clock_duty_correction_enable_o,
  output logic clock_cross_control_enable_o,
  // loop clock test output
  output logic loop_test_clk_o,
  output logic loop_test_en_o,
  // datapath controls
  output logic [3:0] serial_lane_count_o,
  output logic [3:0] interpolation_factor_select_o,
  output dcc_pkg::dcc_interp_e interp_ratio_o,
  output logic interp_reserved_o,
  output logic sinc_compensation_enable_o,
  output logic modulation_oscillator_enable_o,
  output logic filter_bandwidth_select_o,
  output logic dds_modulus_enable_o,
  output logic lower_sideband_o,
  output logic halfband_filter_enable_o
);
  logic rst_s1_r; // reset release stage one
  logic rst_n_r; // synchronised reset
  logic loop_s1_r; // loop clock sync stage one
  logic loop_s2_r; // loop clock sync stage two
  logic loop_s3_r; // previous synced level, for edges
  logic loop_edge_w; // rising loop clock edge
  logic [2:0] clk_pol_r; // invert, duty, cross
  logic test_en_r; // test output enable
  logic [1:0] test_div_r; // test divide select
  logic [3:0] lanes_r; // serial lane count
  logic [3:0] interp_r; // interpolation code
  logic [7:0] datapath_r; // datapath configuration
  logic [7:0] rdata_nxt; // read mux
  logic test_clk_w; // divided loop clock

  // reset released through two flops, asserted at once
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_s1_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r <= rst_s1_r;
    end
  end

  // loop clock crosses in through two flops; edge compares stages two and three
  always_ff @(posedge sys_clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      loop_s1_r <= 1'b0;
      loop_s2_r <= 1'b0;
      loop_s3_r <= 1'b0;
    end else begin
      loop_s1_r <= loop_clk_i;
      loop_s2_r <= loop_s1_r;
      loop_s3_r <= loop_s2_r;
    end
  end
  assign loop_edge_w = loop_s2_r & ~loop_s3_r;

  // clock polarity register
  always_ff @(posedge sys_clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      clk_pol_r <= `DCC_RST_CLK_POL; // see R1 // see R2 // see R3
    end else if (reg_wr_i && reg_addr_i == ADDR_W'(`DCC_ADDR_CLK_POL)) begin
      clk_pol_r <= reg_wdata_i[`DCC_BIT_CLK_INV:`DCC_BIT_CROSS_EN]; // see R13
    end
  end

  // loop clock test register
  always_ff @(posedge sys_clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      test_en_r <= `DCC_RST_TEST_EN;
      test_div_r <= `DCC_RST_TEST_DIV;
    end else if (reg_wr_i && reg_addr_i == ADDR_W'(`DCC_ADDR_LOOP_TEST)) begin
      test_en_r <= reg_wdata_i[`DCC_BIT_TEST_EN]; // see R4
      test_div_r <= reg_wdata_i[`DCC_TEST_DIV_MSB:`DCC_TEST_DIV_LSB]; // see R5
    end
  end

  // lanes and interpolation; stored as written, software keeps the
  // link receive block in soft reset while changing them
  always_ff @(posedge sys_clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      lanes_r <= `DCC_RST_LANES; // see R6
      interp_r <= `DCC_RST_INTERP; // see R8
    end else if (reg_wr_i &&
                 reg_addr_i == ADDR_W'(`DCC_ADDR_LANES_INTERP)) begin
      lanes_r <= reg_wdata_i[`DCC_LANES_MSB:`DCC_LANES_LSB]; // see R6
      interp_r <= reg_wdata_i[`DCC_INTERP_MSB:`DCC_INTERP_LSB]; // see R8
    end
  end

  // datapath configuration; reserved bits 5 and 3 masked off
  always_ff @(posedge sys_clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      datapath_r <= `DCC_RST_DATAPATH; // see R12
    end else if (reg_wr_i && reg_addr_i == ADDR_W'(`DCC_ADDR_DATAPATH)) begin
      datapath_r <= reg_wdata_i & `DCC_MASK_DATAPATH; // see R13
    end
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    rdata_nxt = 8'h00;
    case (reg_addr_i)
      ADDR_W'(`DCC_ADDR_CLK_POL): begin
        rdata_nxt = {5'h00, clk_pol_r}; // see R13
      end
      ADDR_W'(`DCC_ADDR_LOOP_TEST): begin
        rdata_nxt = {test_en_r, 5'h00, test_div_r}; // see R13
      end
      ADDR_W'(`DCC_ADDR_LANES_INTERP): begin
        rdata_nxt = {lanes_r, interp_r};
      end
      ADDR_W'(`DCC_ADDR_DATAPATH): begin
        rdata_nxt = datapath_r;
      end
      default: begin
        rdata_nxt = 8'h00;
      end
    endcase
  end

  // read data registered, one cycle after the strobe
  always_ff @(posedge sys_clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      reg_rdata_o <= 8'h00;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i) begin
        reg_rdata_o <= rdata_nxt;
      end
    end
  end

  // digital clock controls; clock itself re-timed on sys_clk
  always_ff @(posedge sys_clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      digital_clock_invert_o <= `DCC_RST_CLK_INV;
      digital_clock_o <= 1'b0;
      clock_duty_correction_enable_o <= `DCC_RST_DUTY_EN;
      clock_cross_control_enable_o <= `DCC_RST_CROSS_EN;
    end else begin
      digital_clock_invert_o <= clk_pol_r[`DCC_BIT_CLK_INV];
      digital_clock_o <= loop_s2_r ^ clk_pol_r[`DCC_BIT_CLK_INV]; // see R1
      clock_duty_correction_enable_o <= clk_pol_r[`DCC_BIT_DUTY_EN]; // see R2
      clock_cross_control_enable_o <= clk_pol_r[`DCC_BIT_CROSS_EN]; // see R3
    end
  end

  // test clock divider
  dcc_test_div #(
    .CNT_W(4)
  ) u_div (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_r),
    .enable_i(test_en_r),
    .div_sel_i(test_div_r),
    .loop_edge_i(loop_edge_w),
    .test_clk_o(test_clk_w)
  );

  // test output gated by the enable
  always_ff @(posedge sys_clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      loop_test_clk_o <= 1'b0;
      loop_test_en_o <= 1'b0;
    end else begin
      loop_test_clk_o <= test_clk_w & test_en_r; // see R4
      loop_test_en_o <= test_en_r;
    end
  end

  // datapath outputs, including decoded ratio
  always_ff @(posedge sys_clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      serial_lane_count_o <= `DCC_RST_LANES;
      interpolation_factor_select_o <= `DCC_RST_INTERP;
      interp_ratio_o <= dcc_pkg::DCC_INTERP_NONE;
      interp_reserved_o <= 1'b1;
      sinc_compensation_enable_o <= `DCC_RST_EN_OFF;
      modulation_oscillator_enable_o <= `DCC_RST_EN_OFF;
      filter_bandwidth_select_o <= `DCC_RST_EN_OFF;
      dds_modulus_enable_o <= `DCC_RST_EN_OFF;
      lower_sideband_o <= `DCC_RST_EN_OFF;
      halfband_filter_enable_o <= `DCC_RST_EN_OFF;
    end else begin
      serial_lane_count_o <= lanes_r; // see R6
      interpolation_factor_select_o <= interp_r;
      interp_reserved_o <= 1'b0;
      case (interp_r)
        `DCC_INTERP_6X: interp_ratio_o <= dcc_pkg::DCC_INTERP_X6; // see R8
        `DCC_INTERP_8X: interp_ratio_o <= dcc_pkg::DCC_INTERP_X8;
        `DCC_INTERP_12X: interp_ratio_o <= dcc_pkg::DCC_INTERP_X12;
        `DCC_INTERP_16X: interp_ratio_o <= dcc_pkg::DCC_INTERP_X16;
        `DCC_INTERP_24X: interp_ratio_o <= dcc_pkg::DCC_INTERP_X24;
        default: begin
          interp_ratio_o <= dcc_pkg::DCC_INTERP_NONE; // see R8
          interp_reserved_o <= 1'b1;
        end
      endcase
      sinc_compensation_enable_o <= datapath_r[`DCC_BIT_SINC_EN]; // see R9
      modulation_oscillator_enable_o <= datapath_r[`DCC_BIT_MODULATION_OSCILLATOR_ENABLE]; // see R12
      filter_bandwidth_select_o <= datapath_r[`DCC_BIT_FILTER_BANDWIDTH_SELECT]; // see R10
      dds_modulus_enable_o <= datapath_r[`DCC_BIT_DDS_EN]; // see R12
      lower_sideband_o <= datapath_r[`DCC_BIT_SIDEBAND]; // see R11
      halfband_filter_enable_o <= datapath_r[`DCC_BIT_HB_EN]; // see R12
    end
  end
endmodule : dcc_regs

// file: tb/dcc_regs_props.sv
// checker for the configuration bank, watching top ports only
// assumes a bind from the bench top and a single clock domain
`timescale 1ns/1ps
`include "dcc_regs_map.svh"
module dcc_regs_props #(
  parameter int ADDR_W = 12
) (
  // clock and reset
  input logic sys_clk_i,
  input logic reset_n_i,
  // register port
  input logic [ADDR_W-1:0] reg_addr_i,
  input logic reg_wr_i,
  input logic reg_rd_i,
  input logic [7:0] reg_wdata_i,
  input logic [7:0] reg_rdata_o,
  input logic reg_rvalid_o,
  // controls
  input logic digital_clock_invert_o,
  input logic clock_duty_correction_enable_o,
  input logic clock_cross_control_enable_o,
  input logic loop_test_clk_o,
  input logic loop_test_en_o,
  input logic [3:0] serial_lane_count_o,
  input logic [3:0] interpolation_factor_select_o,
  input logic interp_reserved_o,
  input logic sinc_compensation_enable_o,
  input logic modulation_oscillator_enable_o,
  input logic filter_bandwidth_select_o,
  input logic dds_modulus_enable_o,
  input logic lower_sideband_o,
  input logic halfband_filter_enable_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  logic [7:0] rsv_mask; // bits that must read back zero
  // unmapped places read as all zero, hence a full mask
  always_comb begin
    case (reg_addr_i)
      `DCC_ADDR_CLK_POL: rsv_mask = 8'hf8;
      `DCC_ADDR_LOOP_TEST: rsv_mask = 8'h7c;
      `DCC_ADDR_LANES_INTERP: rsv_mask = 8'h00;
      `DCC_ADDR_DATAPATH: rsv_mask = 8'h28;
      default: rsv_mask = 8'hff;
    endcase
  end
  chk_clock_ctrl_write: assert property (
    reg_wr_i && reg_addr_i == `DCC_ADDR_CLK_POL |-> ##2
    {digital_clock_invert_o, clock_duty_correction_enable_o,
     clock_cross_control_enable_o} == $past(reg_wdata_i[2:0], 2))
    else $error("clock control write not applied");
  chk_test_en_write: assert property (
    reg_wr_i && reg_addr_i == `DCC_ADDR_LOOP_TEST |-> ##2
    loop_test_en_o == $past(reg_wdata_i[7], 2))
    else $error("test enable write not applied");
  chk_test_clk_off: assert property (
    !loop_test_en_o && $past(!loop_test_en_o) |-> !loop_test_clk_o)
    else $error("test clock active while disabled");
  chk_lanes_write: assert property (
    reg_wr_i && reg_addr_i == `DCC_ADDR_LANES_INTERP |-> ##2
    {serial_lane_count_o, interpolation_factor_select_o}
    == $past(reg_wdata_i, 2))
    else $error("lane or interpolation write not applied");
  chk_datapath_write: assert property (
    reg_wr_i && reg_addr_i == `DCC_ADDR_DATAPATH |-> ##2
    {sinc_compensation_enable_o, modulation_oscillator_enable_o,
     filter_bandwidth_select_o, dds_modulus_enable_o,
     lower_sideband_o, halfband_filter_enable_o} ==
    {$past(reg_wdata_i[7:6], 2), $past(reg_wdata_i[4], 2),
     $past(reg_wdata_i[2:0], 2)})
    else $error("datapath write not applied");
  chk_read_valid: assert property (
    reg_rd_i |=> reg_rvalid_o)
    else $error("read not answered");
  chk_reserved_zero: assert property (
    reg_rd_i |=> (reg_rdata_o & $past(rsv_mask)) == 8'h00)
    else $error("reserved bits read nonzero");
  chk_interp_flag: assert property (
    $stable(interpolation_factor_select_o) |-> interp_reserved_o ==
    (interpolation_factor_select_o < 4'h4 ||
     interpolation_factor_select_o > 4'h8))
    else $error("reserved interpolation flag wrong");
endmodule : dcc_regs_props

// file: tb/dcc_regs_tb_top.sv
// bench for the configuration bank: register port and test clock
// assumes map header and package are compiled before this file
`timescale 1ns/1ps
`include "dcc_regs_map.svh"
module dcc_regs_tb_top;
  logic sys_clk_i = 0;
  logic reset_n_i = 0;
  logic [11:0] reg_addr_i = 0;
  logic reg_wr_i = 0;
  logic reg_rd_i = 0;
  logic [7:0] reg_wdata_i = 0;
  logic [1:0] lc = 0; // loop clock has a period of four cycles
  wire loop_clk_i = lc[1];
  // loop clock as seen at the last three rising edges
  logic [2:0] lh = 3'h0;
  always @(posedge sys_clk_i) lh <= {lh[1:0], loop_clk_i};
  logic [7:0] reg_rdata_o;
  logic reg_rvalid_o, digital_clock_invert_o, digital_clock_o;
  logic clock_duty_correction_enable_o, clock_cross_control_enable_o;
  logic loop_test_clk_o, loop_test_en_o, interp_reserved_o;
  logic [3:0] serial_lane_count_o, interpolation_factor_select_o;
  dcc_pkg::dcc_interp_e interp_ratio_o;
  logic sinc_compensation_enable_o, modulation_oscillator_enable_o;
  logic filter_bandwidth_select_o, dds_modulus_enable_o;
  logic lower_sideband_o, halfband_filter_enable_o;
  int failures = 0;
  int num_checks = 0;
  // outputs laid out as their register bits
  wire [7:0] dp = {sinc_compensation_enable_o,
    modulation_oscillator_enable_o, 1'b0, filter_bandwidth_select_o,
    1'b0, dds_modulus_enable_o, lower_sideband_o,
    halfband_filter_enable_o};
  wire [7:0] ck = {5'h0, digital_clock_invert_o,
    clock_duty_correction_enable_o, clock_cross_control_enable_o};
  dcc_regs dut (.sys_clk_i, .reset_n_i, .reg_addr_i, .reg_wr_i,
    .reg_rd_i, .reg_wdata_i, .reg_rdata_o, .reg_rvalid_o, .loop_clk_i,
    .digital_clock_invert_o, .digital_clock_o,
    .clock_duty_correction_enable_o, .clock_cross_control_enable_o,
    .loop_test_clk_o, .loop_test_en_o, .serial_lane_count_o,
    .interpolation_factor_select_o, .interp_ratio_o, .interp_reserved_o,
    .sinc_compensation_enable_o, .modulation_oscillator_enable_o,
    .filter_bandwidth_select_o, .dds_modulus_enable_o,
    .lower_sideband_o, .halfband_filter_enable_o);
  // clock and a free running loop clock, changed off the sampling edge
  initial forever #50 sys_clk_i = ~sys_clk_i;
  always @(negedge sys_clk_i) lc <= lc + 2'h1;
  task automatic end_of_test;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    num_checks++;
    if (s !== e) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk
  // one-cycle write strobe, then two edges for outputs to settle
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1;
    @(negedge sys_clk_i);
    reg_wr_i = 0;
    repeat (2) @(negedge sys_clk_i);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    int n;
    reg_addr_i = a;
    reg_rd_i = 1;
    @(negedge sys_clk_i);
    reg_rd_i = 0;
    for (n = 0; n < 4 && reg_rvalid_o !== 1'b1; n++) @(negedge sys_clk_i);
    if (n == 4) begin
      failures++;
      end_of_test();
    end
    chk(reg_rdata_o, e);
    // let an edge pass so a following read raises a fresh strobe
    @(negedge sys_clk_i);
  endtask : rd
  // wait for the test clock to reach a level; bounded
  task automatic till(input logic v, output int n);
    for (n = 0; n < 200 && loop_test_clk_o !== v; n++) @(negedge sys_clk_i);
    if (n == 200) begin
      failures++;
      end_of_test();
    end
  endtask : till
  // digital clock: two sync flops plus output flop, three edges late
  task automatic dclk(input logic inv);
    repeat (8) begin
      @(negedge sys_clk_i);
      chk(digital_clock_o, lh[2] ^ inv);
    end
  endtask : dclk
  task automatic t_reset;
    chk(ck, 8'h03);
    chk({serial_lane_count_o, interpolation_factor_select_o}, 8'h81);
    chk(dp, 8'h00);
    chk(loop_test_clk_o, 8'h00);
    rd(`DCC_ADDR_CLK_POL, 8'h03);
    rd(`DCC_ADDR_LOOP_TEST, 8'h00);
    rd(`DCC_ADDR_LANES_INTERP, 8'h81);
    rd(`DCC_ADDR_DATAPATH, 8'h00);
    rd(12'h09e, 8'h00);
    dclk(1'b0);
  endtask : t_reset
  task automatic t_datapath;
    for (int i = 0; i < 8; i++) begin
      wr(`DCC_ADDR_DATAPATH, 8'h01 << i);
      chk(dp, (8'h01 << i) & 8'hd7);
      rd(`DCC_ADDR_DATAPATH, (8'h01 << i) & 8'hd7);
    end
    wr(12'h112, 8'hff);
    rd(`DCC_ADDR_DATAPATH, 8'h80);
    rd(12'h112, 8'h00);
  endtask : t_datapath
  task automatic t_clock;
    wr(`DCC_ADDR_CLK_POL, 8'hff);
    chk(ck, 8'h07);
    dclk(1'b1);
    rd(`DCC_ADDR_CLK_POL, 8'h07);
    wr(`DCC_ADDR_CLK_POL, 8'h04);
    chk(ck, 8'h04);
  endtask : t_clock
  function automatic dcc_pkg::dcc_interp_e ratio_of(input logic [3:0] c);
    case (c)
      4'h4: return dcc_pkg::DCC_INTERP_X6;
      4'h5: return dcc_pkg::DCC_INTERP_X8;
      4'h6: return dcc_pkg::DCC_INTERP_X12;
      4'h7: return dcc_pkg::DCC_INTERP_X16;
      4'h8: return dcc_pkg::DCC_INTERP_X24;
      default: return dcc_pkg::DCC_INTERP_NONE;
    endcase
  endfunction : ratio_of
  task automatic t_interp;
    logic [3:0] c;
    for (int i = 0; i < 16; i++) begin
      c = 4'(i);
      // link receive block taken as held in soft reset while these change
      wr(`DCC_ADDR_LANES_INTERP, {~c, c});
      chk({serial_lane_count_o, interpolation_factor_select_o}, {~c, c});
      chk(interp_ratio_o, ratio_of(c));
      chk(interp_reserved_o, c < 4'h4 || c > 4'h8);
      rd(`DCC_ADDR_LANES_INTERP, {~c, c});
    end
  endtask : t_interp
  task automatic t_test;
    int a, b, n;
    logic hi;
    for (int d = 0; d < 4; d++) begin
      wr(`DCC_ADDR_LOOP_TEST, 8'hfc | 8'(d));
      rd(`DCC_ADDR_LOOP_TEST, 8'h80 | 8'(d));
      repeat (130) @(negedge sys_clk_i);
      till(1'b0, n);
      till(1'b1, n);
      till(1'b0, a);
      till(1'b1, b);
      chk(8'(a + b), 8'h08 << d);
    end
    wr(`DCC_ADDR_LOOP_TEST, 8'h03);
    hi = 0;
    repeat (80) begin
      @(negedge sys_clk_i);
      hi = hi | loop_test_clk_o;
    end
    chk(hi, 8'h00);
  endtask : t_test
  initial begin
    repeat (10) @(negedge sys_clk_i);
    reset_n_i = 1;
    repeat (3) @(negedge sys_clk_i);
    t_reset();
    t_datapath();
    t_clock();
    t_interp();
    t_test();
    // a second reset in mid-run must restore every default
    reset_n_i = 0;
    repeat (2) @(negedge sys_clk_i);
    reset_n_i = 1;
    repeat (3) @(negedge sys_clk_i);
    t_reset();
    end_of_test();
  end
endmodule : dcc_regs_tb_top
bind dcc_regs dcc_regs_props #(.ADDR_W(ADDR_W)) u_props (.sys_clk_i,
  .reset_n_i, .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i,
  .reg_rdata_o, .reg_rvalid_o, .digital_clock_invert_o,
  .clock_duty_correction_enable_o, .clock_cross_control_enable_o,
  .loop_test_clk_o, .loop_test_en_o, .serial_lane_count_o,
  .interpolation_factor_select_o, .interp_reserved_o,
  .sinc_compensation_enable_o, .modulation_oscillator_enable_o,
  .filter_bandwidth_select_o, .dds_modulus_enable_o, .lower_sideband_o,
  .halfband_filter_enable_o);
